/* File: rtcaef_pkg.sv */
// package of the rtc alarm and event-flag block: register map, field layout, reset values
// assumes a 32-bit apb slave with each register on its own aligned word
package rtcaef_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] RTCAEF_OFS_CMP_EN = 8'h00;
    localparam logic [7:0] RTCAEF_OFS_FLAGS = 8'h04;
    localparam logic [7:0] RTCAEF_OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] RTCAEF_OFS_CTRL = 8'h0c;
    localparam logic [7:0] RTCAEF_OFS_AL_MINUTE = 8'h10;
    localparam logic [7:0] RTCAEF_OFS_AL_HOUR = 8'h14;
    localparam logic [7:0] RTCAEF_OFS_AL_DAY = 8'h18;
    localparam logic [7:0] RTCAEF_OFS_AL_MONTH = 8'h1c;
    localparam logic [7:0] RTCAEF_OFS_AL_YEAR = 8'h20;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RTCAEF_RST_CMP_EN = 8'h00;
    localparam logic [7:0] RTCAEF_RST_FLAGS = 8'h00;
    localparam logic [7:0] RTCAEF_RST_IRQ_EN = 8'h00;
    localparam logic [1:0] RTCAEF_RST_CTRL = 2'h0;
    localparam logic [7:0] RTCAEF_RST_ALARM = 8'h00;

    // ------------------------------------------------------------
    // compare enable fields; bits 7:5 are reserved and read zero
    // ------------------------------------------------------------
    localparam int RTCAEF_CMP_MINUTE = 0;
    localparam int RTCAEF_CMP_HOUR = 1;
    localparam int RTCAEF_CMP_DAY = 2;
    localparam int RTCAEF_CMP_MONTH = 3;
    localparam int RTCAEF_CMP_YEAR = 4;
    localparam int RTCAEF_CMP_FIELDS = 5;
    localparam logic [7:0] RTCAEF_CMP_MASK = 8'h1f;

    // ------------------------------------------------------------
    // event flag positions, same in the interrupt enable register
    // ------------------------------------------------------------
    localparam int RTCAEF_EV_HALF_SEC = 0;
    localparam int RTCAEF_EV_SECOND = 1;
    localparam int RTCAEF_EV_MINUTE = 2;
    localparam int RTCAEF_EV_HOUR = 3;
    localparam int RTCAEF_EV_TIMER = 4;
    localparam int RTCAEF_EV_ALARM = 5;
    localparam int RTCAEF_EV_REWRITE_ERR = 6;
    localparam int RTCAEF_EV_READ_DONE = 7;
    localparam logic [7:0] RTCAEF_RMW_FLAGS = 8'hff;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int RTCAEF_CTRL_RECALL = 0;
    localparam int RTCAEF_CTRL_DET_STOP = 1;

    // half-second pulses without a second step that mark a rewrite error
    localparam logic [1:0] RTCAEF_ERR_HALF_PULSES = 2'h2;

    typedef enum logic [1:0] {
        RTCAEF_BUS_IDLE,
        RTCAEF_BUS_WAIT,
        RTCAEF_BUS_DONE
    } rtcaef_bus_t;

endpackage : rtcaef_pkg

/* File: rtcaef_alarm_cmp.sv */
// alarm comparator: each enabled calendar field against its alarm value
// assumes counters and alarm values are stable bcd bytes on pclk
module rtcaef_alarm_cmp #(
    parameter int FIELDS = 5,
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [FIELDS-1:0] field_enable,
    input wire logic [FIELDS*WIDTH-1:0] counter_value,
    input wire logic [FIELDS*WIDTH-1:0] alarm_value,
    output logic match_rise
);

    // ------------------------------------------------------------
    // per-field comparison
    // ------------------------------------------------------------
    logic [FIELDS-1:0] field_ok;
    logic match;
    logic match_r;

    genvar g;
    generate
        for (g = 0; g < FIELDS; g++) begin : g_field
            // a disabled field never blocks the match
            assign field_ok[g] = !field_enable[g] ||
                (counter_value[g*WIDTH +: WIDTH] == alarm_value[g*WIDTH +: WIDTH]);
        end
    endgenerate

    // no enabled field means no alarm at all
    assign match = (&field_ok) && (|field_enable);

    // ------------------------------------------------------------
    // one pulse on entering coincidence
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_r <= 1'b0;
            match_rise <= 1'b0;
        end else begin
            match_r <= match;
            match_rise <= match && !match_r;
        end
    end

endmodule : rtcaef_alarm_cmp

/* File: rtcaef_top.sv */
// rtc alarm compare enables, event flags and interrupt enables behind an apb slave
// assumes the calendar counters, the timer and the recall logic sit outside and
// hand in one-cycle event pulses synchronous to pclk
// and that software keeps the reserved compare enable bits at zero
//
// Operation
// - compare enable bits 7:5 read zero
// - year compared only when its enable set
// - month compared only when its enable set
// - day compared only when its enable set
// - hour compared only when its enable set
// - minute compared only when its enable set
// - enabled fields all equal sets alarm flag
// - writing 0 clears flag, 1 keeps it
// - flags read as one during rmw read
// - recall transfer completion sets read-complete flag
// - second not advancing during rewrite sets error
// - timer underflow sets its flag
// - hour increment sets hourly flag
// - minute increment sets per-minute flag
// - second increment sets per-second flag
// - half-second pulse sets half-second flag
// - one interrupt enable per flag, same bit
// - two half-second pulses while stopped flag error
module rtcaef_top #(
    parameter int VAL_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rmw_read,
    input wire logic [VAL_W-1:0] year_count,
    input wire logic [VAL_W-1:0] month_count,
    input wire logic [VAL_W-1:0] day_count,
    input wire logic [VAL_W-1:0] hour_count,
    input wire logic [VAL_W-1:0] minute_count,
    input wire logic recall_done,
    input wire logic timer_underflow,
    input wire logic hour_step,
    input wire logic minute_step,
    input wire logic second_step,
    input wire logic half_second_pulse,
    output logic calendar_recall_request,
    output logic second_pulse_detect_stop,
    output logic rtc_irq
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, rtcaef_pkg::RTCAEF_OFS_CMP_EN) ||
            hit(addr, rtcaef_pkg::RTCAEF_OFS_FLAGS) ||
            hit(addr, rtcaef_pkg::RTCAEF_OFS_IRQ_EN) ||
            hit(addr, rtcaef_pkg::RTCAEF_OFS_CTRL) ||
            hit(addr, rtcaef_pkg::RTCAEF_OFS_AL_MINUTE) ||
            hit(addr, rtcaef_pkg::RTCAEF_OFS_AL_HOUR) ||
            hit(addr, rtcaef_pkg::RTCAEF_OFS_AL_DAY) ||
            hit(addr, rtcaef_pkg::RTCAEF_OFS_AL_MONTH) ||
            hit(addr, rtcaef_pkg::RTCAEF_OFS_AL_YEAR);
    endfunction : mapped

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rtcaef_pkg::rtcaef_bus_t bus_r;
    rtcaef_pkg::rtcaef_bus_t bus_nxt;
    logic [7:0] cmp_en_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] irq_en_r;
    logic [7:0] al_minute_r;
    logic [7:0] al_hour_r;
    logic [7:0] al_day_r;
    logic [7:0] al_month_r;
    logic [7:0] al_year_r;
    logic recall_r;
    logic det_stop_r;
    logic [1:0] half_cnt_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    logic wr_go;
    logic wr_lane0;
    logic ctrl_wr;
    logic alarm_rise;
    logic rewrite_err;
    logic [7:0] ev_set;
    logic [7:0] ev_clr;

    // ------------------------------------------------------------
    // apb handshake: one wait state, then pready for one cycle
    // ------------------------------------------------------------
    always_comb begin
        bus_nxt = bus_r;
        case (bus_r)
            rtcaef_pkg::RTCAEF_BUS_IDLE: begin
                if (psel && penable) begin
                    bus_nxt = rtcaef_pkg::RTCAEF_BUS_WAIT;
                end
            end
            rtcaef_pkg::RTCAEF_BUS_WAIT: begin
                bus_nxt = rtcaef_pkg::RTCAEF_BUS_DONE;
            end
            rtcaef_pkg::RTCAEF_BUS_DONE: begin
                bus_nxt = rtcaef_pkg::RTCAEF_BUS_IDLE;
            end
            default: begin
                bus_nxt = rtcaef_pkg::RTCAEF_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_r <= rtcaef_pkg::RTCAEF_BUS_IDLE;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    // answer is loaded in the first access cycle and shown in the second
    // outside that cycle prdata is held at zero so no stale value leaks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= (bus_r == rtcaef_pkg::RTCAEF_BUS_IDLE) && psel && penable;
            pslverr_r <= (bus_r == rtcaef_pkg::RTCAEF_BUS_IDLE) && psel && penable &&
                !mapped(paddr);
            if ((bus_r == rtcaef_pkg::RTCAEF_BUS_IDLE) && psel && penable && !pwrite) begin
                prdata_r <= rdata_nxt;
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // a write takes effect at the edge where pready is seen high;
    // an unmapped write or one without byte lane 0 changes nothing
    assign wr_go = psel && penable && pwrite && pready_r && !pslverr_r;
    assign wr_lane0 = wr_go && pstrb[0];
    assign ctrl_wr = wr_lane0 && hit(paddr, rtcaef_pkg::RTCAEF_OFS_CTRL);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        // bits above each register's width read zero
        rdata_nxt = 32'h0000_0000;
        if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_CMP_EN)) begin
            rdata_nxt[7:0] = cmp_en_r & rtcaef_pkg::RTCAEF_CMP_MASK;
        end else if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_FLAGS)) begin
            // rmw read returns all ones so write-back clears nothing
            rdata_nxt[7:0] = rmw_read ? rtcaef_pkg::RTCAEF_RMW_FLAGS : flags_r;
        end else if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_IRQ_EN)) begin
            rdata_nxt[7:0] = irq_en_r;
        end else if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_CTRL)) begin
            rdata_nxt[rtcaef_pkg::RTCAEF_CTRL_RECALL] = recall_r;
            rdata_nxt[rtcaef_pkg::RTCAEF_CTRL_DET_STOP] = det_stop_r;
        end else if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_MINUTE)) begin
            rdata_nxt[7:0] = al_minute_r;
        end else if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_HOUR)) begin
            rdata_nxt[7:0] = al_hour_r;
        end else if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_DAY)) begin
            rdata_nxt[7:0] = al_day_r;
        end else if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_MONTH)) begin
            rdata_nxt[7:0] = al_month_r;
        end else if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_YEAR)) begin
            rdata_nxt[7:0] = al_year_r;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // only byte lane 0 carries register bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_en_r <= rtcaef_pkg::RTCAEF_RST_CMP_EN;
        end else if (wr_lane0 && hit(paddr, rtcaef_pkg::RTCAEF_OFS_CMP_EN)) begin
            cmp_en_r <= pwdata[7:0] & rtcaef_pkg::RTCAEF_CMP_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= rtcaef_pkg::RTCAEF_RST_IRQ_EN;
        end else if (wr_lane0 && hit(paddr, rtcaef_pkg::RTCAEF_OFS_IRQ_EN)) begin
            irq_en_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            al_minute_r <= rtcaef_pkg::RTCAEF_RST_ALARM;
            al_hour_r <= rtcaef_pkg::RTCAEF_RST_ALARM;
            al_day_r <= rtcaef_pkg::RTCAEF_RST_ALARM;
            al_month_r <= rtcaef_pkg::RTCAEF_RST_ALARM;
            al_year_r <= rtcaef_pkg::RTCAEF_RST_ALARM;
        end else if (wr_lane0) begin
            if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_MINUTE)) begin
                al_minute_r <= pwdata[7:0];
            end
            if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_HOUR)) begin
                al_hour_r <= pwdata[7:0];
            end
            if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_DAY)) begin
                al_day_r <= pwdata[7:0];
            end
            if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_MONTH)) begin
                al_month_r <= pwdata[7:0];
            end
            if (hit(paddr, rtcaef_pkg::RTCAEF_OFS_AL_YEAR)) begin
                al_year_r <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // control: recall request holds until the transfer is done
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recall_r <= rtcaef_pkg::RTCAEF_RST_CTRL[rtcaef_pkg::RTCAEF_CTRL_RECALL];
            det_stop_r <= rtcaef_pkg::RTCAEF_RST_CTRL[rtcaef_pkg::RTCAEF_CTRL_DET_STOP];
        end else begin
            if (ctrl_wr) begin
                det_stop_r <= pwdata[rtcaef_pkg::RTCAEF_CTRL_DET_STOP];
            end
            // a new request wins over a completion in the same cycle
            if (ctrl_wr && pwdata[rtcaef_pkg::RTCAEF_CTRL_RECALL]) begin
                recall_r <= 1'b1;
            end else if (recall_done) begin
                recall_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // alarm comparison; field order minute, hour, day, month, year
    // ------------------------------------------------------------
    // only the rise of a coincidence is taken: a standing match sets the flag once
    rtcaef_alarm_cmp #(
        .FIELDS(rtcaef_pkg::RTCAEF_CMP_FIELDS),
        .WIDTH(VAL_W)
    ) u_alarm_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .field_enable(cmp_en_r[rtcaef_pkg::RTCAEF_CMP_FIELDS-1:0]),
        .counter_value({year_count, month_count, day_count, hour_count, minute_count}),
        .alarm_value({al_year_r, al_month_r, al_day_r, al_hour_r, al_minute_r}),
        .match_rise(alarm_rise)
    );

    // ------------------------------------------------------------
    // rewrite error: half-second pulses counted while detection is
    // stopped; a second step in between restarts the count
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt_r <= 2'h0;
        end else if (!det_stop_r || second_step) begin
            half_cnt_r <= 2'h0;
        end else if (half_second_pulse && (half_cnt_r != rtcaef_pkg::RTCAEF_ERR_HALF_PULSES)) begin
            half_cnt_r <= half_cnt_r + 2'h1;
        end
    end

    // second pulse seen while one is already counted
    // the count holds at its limit, so a run of half-second pulses with no second step flags once
    assign rewrite_err = det_stop_r && !second_step && half_second_pulse &&
        (half_cnt_r == rtcaef_pkg::RTCAEF_ERR_HALF_PULSES - 2'h1);

    // ------------------------------------------------------------
    // event flags: set wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_comb begin
        ev_set = 8'h00;
        ev_set[rtcaef_pkg::RTCAEF_EV_READ_DONE] = recall_done && recall_r;
        ev_set[rtcaef_pkg::RTCAEF_EV_REWRITE_ERR] = rewrite_err;
        ev_set[rtcaef_pkg::RTCAEF_EV_ALARM] = alarm_rise;
        ev_set[rtcaef_pkg::RTCAEF_EV_TIMER] = timer_underflow;
        ev_set[rtcaef_pkg::RTCAEF_EV_HOUR] = hour_step;
        ev_set[rtcaef_pkg::RTCAEF_EV_MINUTE] = minute_step;
        ev_set[rtcaef_pkg::RTCAEF_EV_SECOND] = second_step;
        ev_set[rtcaef_pkg::RTCAEF_EV_HALF_SEC] = half_second_pulse;
    end

    // a zero written clears, a one leaves the flag alone
    assign ev_clr = (wr_lane0 && hit(paddr, rtcaef_pkg::RTCAEF_OFS_FLAGS)) ?
        ~pwdata[7:0] : 8'h00;
    assign flags_nxt = (flags_r & ~ev_clr) | ev_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= rtcaef_pkg::RTCAEF_RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            // follows the registered flags, one cycle behind them
            irq_r <= |(flags_r & irq_en_r);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is driven straight from a flip-flop
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign rtc_irq = irq_r;
    assign calendar_recall_request = recall_r;
    assign second_pulse_detect_stop = det_stop_r;

endmodule : rtcaef_top

/* File: rtcaef_top_props.sv */
// checker of the rtc alarm and event-flag block, watching its ports only
// assumes a bind onto rtcaef_top and a single pclk domain
module rtcaef_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rmw_read,
    input wire logic recall_done,
    input wire logic calendar_recall_request,
    input wire logic second_pulse_detect_stop,
    input wire logic rtc_irq
);
    // ------------------------------------------------------------
    // bus and register properties
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the answer cycle");
    cmp_reserved_a: assert property (pready && !pwrite && paddr == 8'h00
        |-> prdata[31:5] == 27'h0)
        else $error("compare enable upper bits not zero");
    flag_rmw_a: assert property (pready && !pwrite && paddr == 8'h04
        && $past(rmw_read) |-> prdata == 32'hff)
        else $error("flags not all ones on rmw read");
    map_error_a: assert property (pready && paddr > 8'h20 |-> pslverr)
        else $error("unmapped access without error");
    irq_disable_a: assert property (pready && pwrite && paddr == 8'h08 && pstrb[0]
        && pwdata[7:0] == 8'h00 |-> ##2 !rtc_irq)
        else $error("irq with all enables cleared");
    stop_mirror_a: assert property (pready && pwrite && paddr == 8'h0c && pstrb[0]
        |=> second_pulse_detect_stop == $past(pwdata[1]))
        else $error("detect stop does not follow control write");
    recall_clear_a: assert property (calendar_recall_request && recall_done
        && !(pready && pwrite && paddr == 8'h0c) |=> !calendar_recall_request)
        else $error("recall request not cleared on completion");
endmodule : rtcaef_top_chk

bind rtcaef_top rtcaef_top_chk rtcaef_top_chk_inst (.pclk(pclk), .presetn(presetn),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rmw_read(rmw_read), .recall_done(recall_done),
    .calendar_recall_request(calendar_recall_request),
    .second_pulse_detect_stop(second_pulse_detect_stop), .rtc_irq(rtc_irq));

/* File: rtcaef_top_test.sv */
// self-checking bench of the rtc alarm and event-flag block
// assumes the apb slave answers with pready; event inputs are one-cycle pulses
module rtcaef_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, rmw_read, req, stop, irq, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [5:0] ev;
    logic [3:0] strb;
    logic [7:0] cnt [5];
    logic [7:0] al [5];
    logic [32:0] q [$];
    logic [32:0] e;
    int failures, check_count, cyc, seed, i, f;

    rtcaef_top rtcaef_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rmw_read(rmw_read), .year_count(cnt[4]),
        .month_count(cnt[3]), .day_count(cnt[2]), .hour_count(cnt[1]), .minute_count(cnt[0]),
        .recall_done(ev[5]), .timer_underflow(ev[4]), .hour_step(ev[3]),
        .minute_step(ev[2]), .second_step(ev[1]), .half_second_pulse(ev[0]),
        .calendar_recall_request(req), .second_pulse_detect_stop(stop), .rtc_irq(irq));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // expected answer is noted before the transfer starts
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [32:0] x);
        q.push_back(x);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {1'b0, x});
    endtask : rd

    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev <= 6'h0;
        @(posedge pclk);
    endtask : pulse

    task automatic ckirq(input logic x);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({32'h0, irq}, {32'h0, x});
        @(posedge pclk);
    endtask : ckirq

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            failures++;
            report_and_stop;
        end else if (pready === 1'b1) begin
            if (q.size() == 0) begin
                failures++;
                $display("BAD t=%0t got=%h exp=%h", $time, prdata, 32'h0);
            end else begin
                e = q.pop_front();
                chk({pslverr, prdata}, e);
            end
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hac24;
        cyc = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        rmw_read = 1'b0;
        ev = 6'h0;
        strb = 4'hf;
        for (i = 0; i < 5; i++) begin
            al[i] = 8'h10 + 8'(i);
            cnt[i] = al[i] ^ 8'h01;
        end
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(8'h04, 32'h0);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0c, 32'h0);
        apb(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
        wr(8'h00, 32'hff);
        rd(8'h00, 32'h1f);
        for (i = 0; i < 4; i++) begin
            r = $random(seed) & 32'hff;
            wr(8'h08, r);
            rd(8'h08, r);
        end
        wr(8'h08, 32'h0);
        strb <= 4'he;
        wr(8'h08, 32'hff);
        strb <= 4'hf;
        rd(8'h08, 32'h0);
        for (i = 0; i < 5; i++) pulse(i);
        rd(8'h04, 32'h1f);
        rmw_read <= 1'b1;
        rd(8'h04, 32'hff);
        rmw_read <= 1'b0;
        r = 32'h1f;
        for (i = 0; i < 5; i++) begin
            r[i] = 1'b0;
            wr(8'h04, ~(32'h1 << i));
            rd(8'h04, r);
        end
        for (i = 0; i < 5; i++) begin
            wr(8'h08, 32'h1 << i);
            pulse((i + 1) % 5);
            ckirq(1'b0);
            pulse(i);
            ckirq(1'b1);
            wr(8'h04, 32'h0);
            ckirq(1'b0);
        end
        wr(8'h08, 32'h0);
        for (f = 0; f < 5; f++) wr(8'(16 + 4 * f), {24'h0, al[f]});
        for (f = 0; f < 5; f++) begin
            wr(8'h00, 32'h1 << f);
            cnt[f] <= al[f];
            repeat (3) @(posedge pclk);
            rd(8'h04, 32'h20);
            wr(8'h00, 32'h1f);
            wr(8'h04, 32'h0);
            rd(8'h04, 32'h0);
            cnt[f] <= al[f] ^ 8'h01;
        end
        @(posedge pclk);
        for (f = 0; f < 5; f++) cnt[f] <= al[f];
        repeat (3) @(posedge pclk);
        rd(8'h04, 32'h20);
        wr(8'h04, 32'h0);
        wr(8'h0c, 32'h2);
        pulse(0);
        pulse(1);
        pulse(0);
        rd(8'h04, 32'h03);
        pulse(0);
        rd(8'h04, 32'h43);
        wr(8'h0c, 32'h0);
        wr(8'h04, 32'h0);
        pulse(5);
        rd(8'h04, 32'h0);
        wr(8'h0c, 32'h1);
        chk({32'h0, req}, 33'h1);
        pulse(5);
        rd(8'h04, 32'h80);
        chk({32'h0, req}, 33'h0);
        report_and_stop;
    end
endmodule : rtcaef_top_test
